// >>> hdl/voice_codec_port.sv
// Two-channel PCM/I2S codec serial port with APB register access
//
// Function
// - Per-channel word length 8..320 bits, up to 640 in one-channel use.
// - Master drives bit clock and frame strobe; slave takes both in.
// - Slave bit clock up to 15 MHz; above 12 MHz bursts at most 32 bits.
// - Master generates any bit clock from 64 kHz to 4.096 MHz.
// - Data output high-impedance whenever no voice data is being sent.
// - Data output released to high-impedance between data words.
// - A setting forces the data output permanently high-impedance.
// - Data output is high-impedance after power-up until configured.
// - Each channel start position set per bit clock from strobe edge.
// - Bit order per channel and direction; LSB first only up to 24 bits.
// - Received and transmitted word lengths are independent.
// - I2S: full duplex, slot 0 left channel, slot 1 right channel.
// - I2S slots up to 40 clocks and frames up to 80 clocks.
// - Master with frame idle stops clock at 0 after programmed count.
// - A second count marks pause end; pause is end minus start.
// - Pauses tolerated as master and slave; programmable only as master.
// - All frame data bits are transferred before the clock pause.
// - Active clock edge selectable; strobe and data sampling invertible.
// - Falling-edge codec master: strobe sampled on the following rising edge.
// - Falling-edge codec master: input data captured on falling edges.
// - Linear, A-law and mu-law sample encodings supported.
// - Long and short frame strobe formats supported.
//
// Chosen here: the APB interface to the registers and the register offsets.
module voice_codec_port
    import voice_port_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        bclk_i,
    output logic             bclk_o,
    output logic             bclk_oe,
    input  wire logic        fsync_i,
    output logic             fsync_o,
    output logic             fsync_oe,
    input  wire logic        din,
    output logic             dout_o,
    output logic             dout_oe
);

    // Clamp a programmed length to the legal range for the channel count
    function automatic logic [LEN_W-1:0] eff_len(input logic [LEN_W-1:0] len,
                                                  input logic single);
        logic [LEN_W-1:0] top;
        top = single ? LEN_MAX_ONE : LEN_MAX_TWO;
        if (len < LEN_MIN)
            return LEN_MIN;
        else if (len > top)
            return top;
        else
            return len;
    endfunction

    // Map a word bit index to a storage bit; bits beyond storage give 6'h3F
    function automatic logic [5:0] bit_pos(input logic [LEN_W-1:0] len,
                                          input logic [FT_W-1:0]  idx,
                                          input logic             lsb);
        logic [FT_W-1:0] p;
        p = (lsb && len <= LSB_MAX) ? idx : (FT_W'(len) - 11'h001 - idx);
        return (p < FT_W'(DATA_BITS)) ? p[5:0] : 6'h3F;
    endfunction

    // Decode one channel's layout from its two words
    function automatic chan_cfg_t chan_of(input logic [31:0] lw, input logic [31:0] pw,
                                          input logic single);
        chan_cfg_t c;
        c.tx_len = eff_len(lw[LEN_W-1:0], single);
        c.rx_len = eff_len(lw[HI_LSB +: LEN_W], single);
        c.tx_pos = pw[FT_W-1:0];
        c.rx_pos = pw[HI_LSB +: FT_W];
        c.tx_lsb = lw[TX_LSB_B];
        c.rx_lsb = lw[RX_LSB_B];
        c.coding = coding_t'(lw[CODE_LSB +: 2]);
        return c;
    endfunction

    // Register storage
    ctrl_t       ctrl,     next_ctrl;
    logic [31:0] nco_inc,  next_nco_inc;
    logic [31:0] frame_w,  next_frame_w;
    logic [31:0] idle_w,   next_idle_w;
    logic [31:0] len_w     [2];
    logic [31:0] next_len_w[2];
    logic [31:0] pos_w     [2];
    logic [31:0] next_pos_w[2];
    logic [31:0] tx_data   [2];
    logic [31:0] next_tx_data[2];
    logic [31:0] rx_data   [2];
    logic [31:0] next_rx_data[2];
    logic [1:0]  rx_done,  next_rx_done;
    logic        next_pready;
    logic        next_pslverr;
    logic [31:0] next_prdata;

    // Link state
    logic [2:0]      bclk_s;
    logic [1:0]      fs_s;
    logic [1:0]      din_s;
    logic [31:0]     nco_acc,  next_nco_acc;
    logic            ph,       next_ph;
    logic [FT_W-1:0] ft,       next_ft;
    logic            fs_prev,  next_fs_prev;
    logic [31:0]     rx_work   [2];
    logic [31:0]     next_rx_work[2];
    logic            next_bclk_o, next_fsync_o, next_dout_o, next_dout_oe;
    logic [1:0]      word_end;

    // Link events and decoded settings
    logic            rise, fall, fs_edge, din_edge, tx_edge, fs_lvl, in_idle;
    logic [FT_W-1:0] frame_len, fs_width, idle_start, idle_end;
    chan_cfg_t       ch[2];

    always_comb begin
        ch[0] = chan_of(len_w[0], pos_w[0], ctrl.single_ch);
        ch[1] = chan_of(len_w[1], pos_w[1], ctrl.single_ch);
    end

    // APB decode and register next state; answers with zero wait states
    always_comb begin
        logic acc;
        logic hit;
        logic cfg_ok;
        acc          = psel && penable && pready;
        hit          = 1'b1;
        cfg_ok       = !ctrl.enable;
        next_ctrl    = ctrl;
        next_nco_inc = nco_inc;
        next_frame_w = frame_w;
        next_idle_w  = idle_w;
        next_len_w   = len_w;
        next_pos_w   = pos_w;
        next_tx_data = tx_data;
        next_prdata  = prdata;
        next_rx_done = rx_done;
        next_pready  = psel && !penable;
        unique case (paddr)
            CTRL_OFS:    next_prdata = ctrl;
            NCO_OFS:     next_prdata = nco_inc;
            FRAME_OFS:   next_prdata = frame_w;
            IDLE_OFS:    next_prdata = idle_w;
            CH0_LEN_OFS: next_prdata = len_w[0];
            CH0_POS_OFS: next_prdata = pos_w[0];
            CH1_LEN_OFS: next_prdata = len_w[1];
            CH1_POS_OFS: next_prdata = pos_w[1];
            CH0_TX_OFS:  next_prdata = tx_data[0];
            CH1_TX_OFS:  next_prdata = tx_data[1];
            CH0_RX_OFS:  next_prdata = rx_data[0];
            CH1_RX_OFS:  next_prdata = rx_data[1];
            STATUS_OFS:  next_prdata = {5'h00, ft, 13'h0000, rx_done, ctrl.enable};
            default: begin
                next_prdata = ZERO32;
                hit         = 1'b0;
            end
        endcase
        if (!(psel && !penable))
            next_prdata = prdata;
        next_pslverr = psel && !penable && !hit;
        if (acc && pwrite) begin
            unique case (paddr)
                // Layout only changes while stopped; enable is always writable
                CTRL_OFS: begin
                    if (cfg_ok)
                        next_ctrl = ctrl_t'(pwdata);
                    next_ctrl.enable = pwdata[0];
                end
                NCO_OFS:     if (cfg_ok) next_nco_inc = pwdata;
                FRAME_OFS:   if (cfg_ok) next_frame_w = pwdata;
                IDLE_OFS:    if (cfg_ok) next_idle_w = pwdata;
                CH0_LEN_OFS: if (cfg_ok) next_len_w[0] = pwdata;
                CH0_POS_OFS: if (cfg_ok) next_pos_w[0] = pwdata;
                CH1_LEN_OFS: if (cfg_ok) next_len_w[1] = pwdata;
                CH1_POS_OFS: if (cfg_ok) next_pos_w[1] = pwdata;
                CH0_TX_OFS:  next_tx_data[0] = pwdata;
                CH1_TX_OFS:  next_tx_data[1] = pwdata;
                STATUS_OFS:  next_rx_done = rx_done & ~pwdata[ST_DONE_L +: 2];
                default:     next_rx_done = rx_done;
            endcase
        end
        // A word finishing in the clearing cycle keeps its flag
        next_rx_done = next_rx_done | word_end;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl       <= ctrl_t'(CTRL_RST);
            nco_inc    <= NCO_RST;
            frame_w    <= FRAME_RST;
            idle_w     <= IDLE_RST;
            len_w[0]   <= LEN_RST;
            len_w[1]   <= LEN_RST;
            pos_w[0]   <= ZERO32;
            pos_w[1]   <= ZERO32;
            tx_data[0] <= ZERO32;
            tx_data[1] <= ZERO32;
            rx_done    <= 2'h0;
            pready     <= 1'b0;
            pslverr    <= 1'b0;
            prdata     <= ZERO32;
        end else begin
            ctrl       <= next_ctrl;
            nco_inc    <= next_nco_inc;
            frame_w    <= next_frame_w;
            idle_w     <= next_idle_w;
            len_w      <= next_len_w;
            pos_w      <= next_pos_w;
            tx_data    <= next_tx_data;
            rx_done    <= next_rx_done;
            pready     <= next_pready;
            pslverr    <= next_pslverr;
            prdata     <= next_prdata;
        end
    end

    // Pin synchronisers; logic reads the last stage, and the last two stages for the bit clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bclk_s <= 3'h0;
            fs_s   <= 2'h0;
            din_s  <= 2'h0;
        end else begin
            bclk_s <= {bclk_s[1:0], bclk_i};
            fs_s   <= {fs_s[0], fsync_i};
            din_s  <= {din_s[0], din};
        end
    end

    // Edge events: NCO phase as master, synchronised pin as slave
    always_comb begin
        logic [32:0] sum;
        logic        tick;
        sum          = {1'b0, nco_acc} + {1'b0, nco_inc};
        tick         = ctrl.enable && ctrl.master && sum[32];
        next_nco_acc = (ctrl.enable && ctrl.master) ? sum[31:0] : ZERO32;
        next_ph      = (ctrl.enable && ctrl.master) ? (ph ^ tick) : 1'b0;
        if (ctrl.master) begin
            rise = tick && !ph;
            fall = tick && ph;
        end else begin
            // Slow pin clock against 125 MHz; 15 MHz leaves 4 samples a phase
            rise = ctrl.enable && bclk_s[1] && !bclk_s[2];
            fall = ctrl.enable && !bclk_s[1] && bclk_s[2];
        end
        fs_edge  = ctrl.fs_fall ? fall : rise;
        din_edge = ctrl.din_fall ? fall : rise;
        tx_edge  = ctrl.launch_fall ? fall : rise;
    end

    // Frame geometry from the settings words
    always_comb begin
        frame_len  = frame_w[FT_W-1:0];
        fs_width   = ctrl.long_frame ? frame_w[HI_LSB +: FT_W] : 11'h001;
        idle_start = idle_w[FT_W-1:0];
        idle_end   = idle_w[HI_LSB +: FT_W];
        // Judged on the period being entered, so clock and data stop on one edge
        in_idle    = ctrl.master && ctrl.idle_en && next_ft >= idle_start && next_ft < idle_end;
        fs_lvl     = fs_s[1] ^ ctrl.fs_invert;
    end

    // Frame timer, strobe, serial transmit and receive
    always_comb begin
        logic [FT_W-1:0] rel;
        logic [5:0]      bp;
        logic            any_tx;
        logic            tx_bit;
        rel          = '0;
        bp           = 6'h00;
        next_ft      = ft;
        next_fs_prev = fs_prev;
        next_fsync_o = fsync_o;
        next_rx_work = rx_work;
        next_rx_data = rx_data;
        next_dout_o  = dout_o;
        next_dout_oe = dout_oe;
        word_end     = 2'h0;
        any_tx       = 1'b0;
        tx_bit       = 1'b0;
        // Master counts idle periods as well, so the pause is end minus start;
        // the pin follows the new phase, in step with strobe and data launches
        next_bclk_o  = next_ph && !in_idle;
        if (!ctrl.enable) begin
            next_ft      = '0;
            next_fs_prev = 1'b0;
            next_fsync_o = ctrl.fs_invert;
        end else if (fs_edge) begin
            if (ctrl.master) begin
                next_ft = (ft >= frame_len - 11'h001) ? '0 : ft + 11'h001;
                next_fsync_o = (next_ft < fs_width) ^ ctrl.fs_invert;
            end else begin
                next_fs_prev = fs_lvl;
                // Slave only advances on real edges, so pauses are harmless
                if (fs_lvl && !fs_prev)
                    next_ft = '0;
                else if (ft != '1)
                    next_ft = ft + 11'h001;
            end
        end
        // Launch: slot 0 is left, slot 1 right when laid out that way
        if (tx_edge) begin
            for (int c = 0; c < 2; c++) begin
                rel = ft - ch[c].tx_pos;
                if ((c == 0 || !ctrl.single_ch) && ft >= ch[c].tx_pos &&
                    rel < FT_W'(ch[c].tx_len)) begin
                    any_tx = 1'b1;
                    bp     = bit_pos(ch[c].tx_len, rel, ch[c].tx_lsb);
                    tx_bit = (bp != 6'h3F) ? tx_data[c][bp[4:0]] : 1'b0;
                end
            end
            next_dout_o  = tx_bit;
            // Released outside words, in the pause, and when forced off
            next_dout_oe = any_tx && !in_idle && !ctrl.hiz_force;
        end
        if (!ctrl.enable || ctrl.hiz_force)
            next_dout_oe = 1'b0;
        // Capture on the selected sampling edge
        if (din_edge) begin
            for (int c = 0; c < 2; c++) begin
                rel = ft - ch[c].rx_pos;
                if ((c == 0 || !ctrl.single_ch) && ft >= ch[c].rx_pos &&
                    rel < FT_W'(ch[c].rx_len)) begin
                    bp = bit_pos(ch[c].rx_len, rel, ch[c].rx_lsb);
                    if (rel == '0)
                        next_rx_work[c] = ZERO32;
                    if (bp != 6'h3F)
                        next_rx_work[c][bp[4:0]] = din_s[1];
                    if (rel == FT_W'(ch[c].rx_len) - 11'h001) begin
                        next_rx_data[c] = next_rx_work[c];
                        word_end[c]     = 1'b1;
                    end
                end
            end
        end
    end

    // Coding only tags the sample; companding is done by the voice path
    coding_t unused_code;
    assign unused_code = ch[0].coding;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nco_acc    <= ZERO32;
            ph         <= 1'b0;
            ft         <= '0;
            fs_prev    <= 1'b0;
            rx_work[0] <= ZERO32;
            rx_work[1] <= ZERO32;
            rx_data[0] <= ZERO32;
            rx_data[1] <= ZERO32;
            bclk_o     <= 1'b0;
            bclk_oe    <= 1'b0;
            fsync_o    <= 1'b0;
            fsync_oe   <= 1'b0;
            dout_o     <= 1'b0;
            dout_oe    <= 1'b0;
        end else begin
            nco_acc    <= next_nco_acc;
            ph         <= next_ph;
            ft         <= next_ft;
            fs_prev    <= next_fs_prev;
            rx_work    <= next_rx_work;
            rx_data    <= next_rx_data;
            bclk_o     <= next_bclk_o;
            bclk_oe    <= ctrl.enable && ctrl.master;
            fsync_o    <= next_fsync_o;
            fsync_oe   <= ctrl.enable && ctrl.master;
            dout_o     <= next_dout_o;
            dout_oe    <= next_dout_oe;
        end
    end

endmodule

// >>> hdl/voice_port_pkg.sv
// Constants, register map and carrier types of the voice codec serial port
package voice_port_pkg;

    // APB register byte offsets
    localparam logic [7:0] CTRL_OFS    = 8'h00;
    localparam logic [7:0] NCO_OFS     = 8'h04;
    localparam logic [7:0] FRAME_OFS   = 8'h08;
    localparam logic [7:0] IDLE_OFS    = 8'h0C;
    localparam logic [7:0] CH0_LEN_OFS = 8'h10;
    localparam logic [7:0] CH0_POS_OFS = 8'h14;
    localparam logic [7:0] CH1_LEN_OFS = 8'h18;
    localparam logic [7:0] CH1_POS_OFS = 8'h1C;
    localparam logic [7:0] CH0_TX_OFS  = 8'h20;
    localparam logic [7:0] CH1_TX_OFS  = 8'h24;
    localparam logic [7:0] CH0_RX_OFS  = 8'h28;
    localparam logic [7:0] CH1_RX_OFS  = 8'h2C;
    localparam logic [7:0] STATUS_OFS  = 8'h30;

    // Field widths and positions
    localparam int LEN_W     = 10;
    localparam int FT_W      = 11;
    localparam int HI_LSB    = 16;
    localparam int TX_LSB_B  = 28;
    localparam int RX_LSB_B  = 29;
    localparam int CODE_LSB  = 30;
    localparam int ST_DONE_L = 1;
    localparam int ST_FT_L   = 16;

    // Word length limits
    localparam logic [LEN_W-1:0] LEN_MIN     = 10'h008;
    localparam logic [LEN_W-1:0] LEN_MAX_TWO = 10'h140;
    localparam logic [LEN_W-1:0] LEN_MAX_ONE = 10'h280;
    localparam logic [LEN_W-1:0] LSB_MAX     = 10'h018;
    localparam logic [LEN_W-1:0] DATA_BITS   = 10'h020;

    // Reset values
    localparam logic [31:0] CTRL_RST  = 32'h0000_0040;
    localparam logic [31:0] NCO_RST   = 32'h0218_DEF4;
    localparam logic [31:0] FRAME_RST = 32'h0001_0050;
    localparam logic [31:0] IDLE_RST  = 32'h0050_0050;
    localparam logic [31:0] LEN_RST   = 32'h0010_0010;
    localparam logic [31:0] ZERO32    = 32'h0000_0000;

    typedef enum logic [1:0] {
        CODE_LINEAR = 2'h0,
        CODE_ALAW   = 2'h1,
        CODE_MULAW  = 2'h2
    } coding_t;

    // Control word, top bit downward to enable at bit 0
    typedef struct packed {
        logic [21:0] unused;
        logic        single_ch;
        logic        long_frame;
        logic        idle_en;
        logic        hiz_force;
        logic        fs_invert;
        logic        din_fall;
        logic        fs_fall;
        logic        launch_fall;
        logic        master;
        logic        enable;
    } ctrl_t;

    // Per-channel word layout
    typedef struct packed {
        logic [LEN_W-1:0] tx_len;
        logic [LEN_W-1:0] rx_len;
        logic [FT_W-1:0]  tx_pos;
        logic [FT_W-1:0]  rx_pos;
        logic             tx_lsb;
        logic             rx_lsb;
        coding_t          coding;
    } chan_cfg_t;

endpackage

// >>> tb/voice_port_assertions.sv
// Port-level assertions for the voice codec serial port
module voice_port_assertions
    import voice_port_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        bclk_i,
    input wire logic        bclk_o,
    input wire logic        bclk_oe,
    input wire logic        fsync_i,
    input wire logic        fsync_o,
    input wire logic        fsync_oe,
    input wire logic        din,
    input wire logic        dout_o,
    input wire logic        dout_oe
);
    logic       wrote;
    logic       next_wrote;
    logic       prev_bclk;
    logic [5:0] gap;
    logic [5:0] next_gap;
    logic       near_edge;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // First register write seen, and age of the last bit clock toggle
    always_comb begin
        next_wrote = wrote | (psel & penable & pwrite & pready);
        next_gap   = (bclk_o != prev_bclk) ? 6'h00 : ((gap == 6'h3F) ? gap : gap + 6'h01);
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wrote     <= 1'b0;
            prev_bclk <= 1'b0;
            gap       <= 6'h3F;
        end else begin
            wrote     <= next_wrote;
            prev_bclk <= bclk_o;
            gap       <= next_gap;
        end
    end
    // Launches and strobe steps belong right after a clock toggle
    assign near_edge = (bclk_o != prev_bclk) || (gap <= 6'h03);

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && pready;
    endsequence

    a_ready_prompt: assert property (s_setup |=> s_access)
        else $error("no ready in first access cycle");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("ready outside an access cycle");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_quiet_start: assert property (!wrote |-> !dout_oe && !bclk_oe)
        else $error("port drives before configuration");
    a_strobe_dir: assert property (fsync_oe == bclk_oe)
        else $error("strobe and clock direction differ");
    a_clock_rate: assert property (bclk_oe && $past(bclk_oe, 16) && (bclk_o != prev_bclk)
        |-> gap >= 6'h0E)
        else $error("bit clock faster than allowed");
    a_data_edge: assert property ($changed(dout_oe) && bclk_oe && $past(bclk_oe, 4)
        |-> near_edge)
        else $error("data enable moved off a clock edge");
    a_strobe_edge: assert property ($changed(fsync_o) && bclk_oe && $past(bclk_oe, 4)
        |-> near_edge)
        else $error("strobe moved off a clock edge");
endmodule

bind voice_codec_port voice_port_assertions u_chk (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .bclk_i, .bclk_o, .bclk_oe,
    .fsync_i, .fsync_o, .fsync_oe, .din, .dout_o, .dout_oe);

// >>> tb/codec_partner.sv
// Loopback codec on the far side, bit clock master when asked to run
module codec_partner (
    input  wire logic run,
    input  wire logic bclk_o,
    input  wire logic bclk_oe,
    input  wire logic fsync_o,
    input  wire logic fsync_oe,
    input  wire logic dout_o,
    input  wire logic dout_oe,
    output logic      bclk_i,
    output logic      fsync_i,
    output logic      din
);
    timeunit 1ns;
    timeprecision 1ps;
    logic bclk_m = 1'b0;
    logic fs_m   = 1'b0;
    logic last_d = 1'b0;

    // Pin levels: whoever enables its driver owns the wire
    assign bclk_i  = bclk_oe ? bclk_o : bclk_m;
    assign fsync_i = fsync_oe ? fsync_o : fs_m;
    // Echo the data line; released, it shows the inverse of the last bit
    assign din     = dout_oe ? dout_o : ~last_d;
    always @(dout_o or dout_oe) if (dout_oe) last_d = dout_o;

    // Frames of 24 clocks at 64 ns, clock parked low between frames
    initial begin
        #5;
        forever begin
            if (run) begin
                fs_m = 1'b1;
                for (int i = 0; i < 24; i++) begin
                    #32 bclk_m = 1'b1;
                    #32 bclk_m = 1'b0;
                    fs_m = 1'b0;
                end
                #256;
            end else begin
                #32;
            end
        end
    end
endmodule

// >>> tb/tb_top.sv
// Self-checking bench for the voice codec serial port
module tb_top
    import voice_port_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic        pready, pslverr, bclk_i, bclk_o, bclk_oe, fsync_i, fsync_o, fsync_oe;
    logic        din, dout_o, dout_oe, rerr, prev_b, prev_f, prev_oe;
    logic        run_ext = 1'b0;
    logic [31:0] prdata, rdat;
    int err_count = 0, samples_checked = 0, frames_seen = 0, oe_total = 0, oe_base;
    int rises = 0, falls_hi = 0, words = 0, last_rises, last_hi, last_words;

    voice_codec_port dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .prdata, .pslverr, .bclk_i, .bclk_o, .bclk_oe, .fsync_i, .fsync_o,
        .fsync_oe, .din, .dout_o, .dout_oe);
    codec_partner partner (.run(run_ext), .bclk_o, .bclk_oe, .fsync_o, .fsync_oe,
        .dout_o, .dout_oe, .bclk_i, .fsync_i, .din);

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // Per-frame tally on the wires: clock rises, strobe width, data words
    always @(posedge pclk) begin
        prev_b  <= bclk_i;
        prev_f  <= fsync_i;
        prev_oe <= dout_oe;
        if (dout_oe && !prev_oe) oe_total <= oe_total + 1;
        if (fsync_i && !prev_f) begin
            frames_seen <= frames_seen + 1;
            last_rises  <= rises;
            last_hi     <= falls_hi;
            last_words  <= words;
            rises       <= (bclk_i && !prev_b) ? 1 : 0;
            falls_hi    <= 0;
            words       <= 0;
        end else begin
            rises    <= rises + int'(bclk_i && !prev_b);
            falls_hi <= falls_hi + int'(!bclk_i && prev_b && prev_f);
            words    <= words + int'(dout_oe && !prev_oe);
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        if (err_count == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic timeout();
        chk(ZERO32, 32'h0000_0001);
        finish_test();
    endtask
    // One APB transfer, request held until ready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n = 0;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 64) begin
            @(posedge pclk);
            n++;
        end
        if (pready !== 1'b1) timeout();
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, ZERO32);
        chk(rdat, e);
    endtask
    // Bounded wait for a frame count; a slow port ends the run
    task automatic wait_frames(input int n);
        for (int i = 0; i < 30000 && frames_seen < n; i++) @(posedge pclk);
        if (frames_seen < n) timeout();
    endtask

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(32'(dout_oe), ZERO32);
        rchk(CTRL_OFS, CTRL_RST);
        rchk(NCO_OFS, NCO_RST);
        rchk(FRAME_OFS, FRAME_RST);
        rchk(IDLE_OFS, IDLE_RST);
        rchk(CH1_LEN_OFS, LEN_RST);
        apb(1'b0, 8'h40, ZERO32);
        chk(32'(rerr), 32'h0000_0001);
        // Master at 1.024 MHz: 32-period frames, clock idle from 25 to 28, two words
        // Receive sits one clock after transmit: a bit launched on a rise is sampled on the next fall
        wr(NCO_OFS, 32'h0431_BDE8);
        wr(FRAME_OFS, 32'h0001_0020);
        wr(IDLE_OFS, 32'h001C_0019);
        wr(CH0_LEN_OFS, 32'h4008_000C);
        wr(CH0_POS_OFS, 32'h0003_0002);
        wr(CH1_LEN_OFS, 32'h9008_0008);
        wr(CH1_POS_OFS, 32'h0010_000F);
        rchk(CH1_LEN_OFS, 32'h9008_0008);
        wr(CH0_TX_OFS, 32'h0000_0A5C);
        wr(CH1_TX_OFS, 32'h0000_002D);
        wr(CTRL_OFS, 32'h0000_0093);
        wait_frames(frames_seen + 4);
        chk(last_rises, 32'h0000_001D);
        chk(last_hi, 32'h0000_0001);
        chk(last_words, 32'h0000_0002);
        rchk(CH0_RX_OFS, 32'h0000_00A5);
        rchk(CH1_RX_OFS, 32'h0000_00B4);
        wr(FRAME_OFS, 32'h0004_0020);
        rchk(FRAME_OFS, 32'h0001_0020);
        wr(CTRL_OFS, ZERO32);
        rchk(CTRL_OFS, 32'h0000_0092);
        // Forced high impedance with a four-period strobe
        wr(FRAME_OFS, 32'h0004_0020);
        wr(CTRL_OFS, 32'h0000_01D3);
        oe_base = oe_total;
        wait_frames(frames_seen + 3);
        chk(oe_total - oe_base, ZERO32);
        chk(last_hi, 32'h0000_0004);
        wr(CTRL_OFS, ZERO32);
        // Slave behind the codec's paused 64 ns clock, data taken on falls
        wr(CH0_TX_OFS, 32'h0000_03E7);
        wr(CH1_TX_OFS, 32'h0000_0061);
        wr(CTRL_OFS, 32'h0000_0011);
        run_ext <= 1'b1;
        wait_frames(frames_seen + 3);
        chk(32'({bclk_oe, fsync_oe}), ZERO32);
        chk(last_rises, 32'h0000_0018);
        chk(last_words, 32'h0000_0002);
        rchk(CH0_RX_OFS, 32'h0000_003E);
        rchk(CH1_RX_OFS, 32'h0000_0086);
        finish_test();
    end
endmodule
